// file: include/nmac_pkg.sv
`default_nettype none
package nmac_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;

	// Word offsets on the register bus
	localparam logic [ADDR_W-1:0] OFF_FIRST  = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SECOND = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_DEST   = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CMD    = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_EXC    = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_COND   = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_MASK   = 4'h7;

	// Command word bits
	localparam int CMD_SAT_BIT = 0;
	localparam int CMD_OVE_BIT = 1;
	localparam int CMD_REC_BIT = 2;

	// Fixed-point exception register bits
	localparam int EXC_OVF_BIT = 0;
	localparam int EXC_SO_BIT  = 1;

	// Interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVF_BIT  = 1;
	localparam int IRQ_W        = 2;

	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SAT_MAX   = 32'h7fff_ffff;
	localparam logic [DATA_W-1:0] SAT_MIN   = 32'h8000_0000;

	typedef struct packed {
		logic record;
		logic ovf_en;
		logic saturate;
	} mac_form_t;

	typedef struct packed {
		logic so;
		logic overflow_flag;
	} exc_t;

	typedef struct packed {
		logic lt;
		logic gt;
		logic eq;
		logic so;
	} cond_t;

endpackage
`default_nettype wire

// file: design/neg_mac_cross_halfword.sv
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE_01: Multiply low halfword of first source by high halfword of second, signed.
// RULE_02: Subtract the product from the destination, forming a 33-bit result.
// RULE_03: Modulo forms keep the low 32 bits of that result unclamped.
// RULE_04: Saturating forms clamp on overflow, else keep the low 32 bits.
// RULE_05: Plain forms change only the destination, no flags.
// RULE_06: Record forms update condition field zero from the written value.
// RULE_07: Overflow-enabled forms update overflow and summary-overflow flags only.
// RULE_08: Overflow-enabled record forms update both flags and condition field.
// RULE_09: Clamp to 7fffffff or 80000000 when bits 32 and 31 differ.
// RULE_10: Overflow flag follows each result; summary overflow is sticky.
module neg_mac_cross_halfword
	import nmac_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] writedata,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	output logic                   irq
);

	logic [DATA_W-1:0] first_source_register;
	logic [DATA_W-1:0] second_source_register;
	logic [DATA_W-1:0] dest;
	exc_t              fixed_point_exception_register;
	cond_t             condition_field_zero;
	logic [IRQ_W-1:0]  status;
	logic [IRQ_W-1:0]  mask;

	logic [DATA_W-1:0] next_first;
	logic [DATA_W-1:0] next_second;
	logic [DATA_W-1:0] next_dest;
	exc_t              next_exc;
	cond_t             next_cond;
	logic [IRQ_W-1:0]  next_status;
	logic [IRQ_W-1:0]  next_mask;
	logic [DATA_W-1:0] next_readdata;
	logic              next_waitrequest;
	logic              next_irq;

	logic              accept;
	logic              exec;
	mac_form_t         form;
	logic signed [31:0] product;
	logic [32:0]       inter;
	logic              ovf;
	logic [DATA_W-1:0] result;
	logic [IRQ_W-1:0]  events;

	// Bus answers one cycle after the request is seen
	assign accept = (read || write) && !waitrequest;
	assign exec   = accept && write && (address == OFF_CMD);
	assign form   = mac_form_t'(writedata[CMD_REC_BIT:CMD_SAT_BIT]);

	always_comb begin
		product = $signed(first_source_register[15:0])
			* $signed(second_source_register[31:16]); // RULE_01
		inter = {dest[31], dest} - {product[31], product}; // RULE_02
		ovf = inter[32] ^ inter[31]; // RULE_09
		if (form.saturate && ovf) begin
			result = inter[32] ? SAT_MIN : SAT_MAX; // RULE_04 RULE_09
		end else begin
			result = inter[31:0]; // RULE_03
		end
	end

	always_comb begin
		next_first       = first_source_register;
		next_second      = second_source_register;
		next_dest        = dest;
		next_exc         = fixed_point_exception_register;
		next_cond        = condition_field_zero;
		next_status      = status;
		next_mask        = mask;
		next_readdata    = readdata;
		next_waitrequest = 1'b1;
		events           = '0;
		if ((read || write) && waitrequest) begin
			next_waitrequest = 1'b0;
			unique case (address)
				OFF_FIRST:  next_readdata = first_source_register;
				OFF_SECOND: next_readdata = second_source_register;
				OFF_DEST:   next_readdata = dest;
				OFF_EXC:    next_readdata = {30'h0,
					fixed_point_exception_register};
				OFF_COND:   next_readdata = {28'h0, condition_field_zero};
				OFF_STATUS: next_readdata = {30'h0, status};
				OFF_MASK:   next_readdata = {30'h0, mask};
				default:    next_readdata = REG_RESET;
			endcase
		end
		if (accept && write) begin
			unique case (address)
				OFF_FIRST:  next_first = writedata;
				OFF_SECOND: next_second = writedata;
				OFF_DEST:   next_dest = writedata;
				OFF_EXC:    next_exc = exc_t'(writedata[1:0]);
				OFF_MASK:   next_mask = writedata[IRQ_W-1:0];
				default:    next_dest = dest;
			endcase
		end
		if (exec) begin
			next_dest = result; // RULE_03 RULE_04 RULE_05
			events[IRQ_DONE_BIT] = 1'b1;
			events[IRQ_OVF_BIT] = ovf;
			if (form.ovf_en) begin
				next_exc.overflow_flag = ovf; // RULE_07 RULE_10
				// Summary overflow sets here or on a bus write to the exception register
				next_exc.so = fixed_point_exception_register.so | ovf;
			end
			if (form.record) begin
				next_cond.lt = result[31]; // RULE_06 RULE_08
				next_cond.gt = !result[31] && (result != '0);
				next_cond.eq = (result == '0);
				next_cond.so = next_exc.so;
			end
		end
		// Read clears status, but a same-cycle event still lands
		if (accept && read && (address == OFF_STATUS)) begin
			next_status = '0;
		end
		next_status = next_status | events;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			first_source_register          <= REG_RESET;
			second_source_register         <= REG_RESET;
			dest                           <= REG_RESET;
			fixed_point_exception_register <= '0;
			condition_field_zero           <= '0;
			status                         <= '0;
			mask                           <= '0;
			readdata                       <= REG_RESET;
			waitrequest                    <= 1'b1;
			irq                            <= 1'b0;
		end else begin
			first_source_register          <= next_first;
			second_source_register         <= next_second;
			dest                           <= next_dest;
			fixed_point_exception_register <= next_exc;
			condition_field_zero           <= next_cond;
			status                         <= next_status;
			mask                           <= next_mask;
			readdata                       <= next_readdata;
			waitrequest                    <= next_waitrequest;
			irq                            <= next_irq;
		end
	end

	// Independent reference for the checks below
	logic signed [31:0] ref_product;
	logic [32:0]        ref_inter;
	// Sign-extended by hand so the check does not share the datapath's form
	assign ref_product = {{16{first_source_register[15]}},
			first_source_register[15:0]}
		* {{16{second_source_register[31]}},
			second_source_register[31:16]};
	assign ref_inter = {dest[31], dest} - {ref_product[31], ref_product};

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	modulo_result_a: assert property ( // RULE_02 RULE_03
		exec && !form.saturate
		|=> dest == $past(dest) - $past(ref_product))
		else $error("modulo result wrong");

	sat_pass_a: assert property ( // RULE_04
		exec && form.saturate && (ref_inter[32] == ref_inter[31])
		|=> dest == $past(ref_inter[31:0]))
		else $error("saturating form changed an in-range value");

	sat_high_a: assert property ( // RULE_09
		exec && form.saturate && !ref_inter[32] && ref_inter[31]
		|=> dest == 32'h7fff_ffff)
		else $error("positive clamp wrong");

	sat_low_a: assert property ( // RULE_09
		exec && form.saturate && ref_inter[32] && !ref_inter[31]
		|=> dest == 32'h8000_0000)
		else $error("negative clamp wrong");

	plain_flags_a: assert property ( // RULE_05
		exec && !form.ovf_en && !form.record
		|=> $stable(fixed_point_exception_register)
			&& $stable(condition_field_zero))
		else $error("plain form touched flags");

	record_cond_a: assert property ( // RULE_06
		exec && form.record && !form.ovf_en
		|=> $stable(fixed_point_exception_register)
			&& condition_field_zero.eq == (dest == 32'h0)
			&& condition_field_zero.lt == dest[31])
		else $error("record form flags wrong");

	ovf_only_a: assert property ( // RULE_07
		exec && form.ovf_en && !form.record
		|=> $stable(condition_field_zero)
			&& fixed_point_exception_register.overflow_flag
				== $past(ref_inter[32] ^ ref_inter[31]))
		else $error("overflow form flags wrong");

	both_forms_a: assert property ( // RULE_08
		exec && form.ovf_en && form.record
		|=> condition_field_zero.so == fixed_point_exception_register.so
			&& condition_field_zero.gt
				== (!dest[31] && dest != 32'h0))
		else $error("combined form flags disagree");

	so_sticky_a: assert property ( // RULE_10
		fixed_point_exception_register.so
		&& !(accept && write && address == OFF_EXC)
		|=> fixed_point_exception_register.so)
		else $error("summary overflow dropped");

	bus_answer_a: assert property (
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");

	product_cross_a: assert property ( // RULE_01
		exec |-> product == ref_product)
		else $error("cross halfword product wrong");

	inter_wide_a: assert property ( // RULE_02
		exec |-> inter == ref_inter)
		else $error("intermediate result wrong");

	ov_follows_a: assert property ( // RULE_10
		exec && form.ovf_en && !ovf
		|=> !fixed_point_exception_register.overflow_flag
			&& $stable(fixed_point_exception_register.so))
		else $error("overflow flag not cleared");

	so_sets_a: assert property ( // RULE_10
		exec && form.ovf_en && ovf
		|=> fixed_point_exception_register.so
			&& fixed_point_exception_register.overflow_flag)
		else $error("summary overflow not set");

	// Events win over a clearing read, so none may be lost
	status_set_a: assert property (
		exec |=> status[IRQ_DONE_BIT]
			&& (status[IRQ_OVF_BIT] || !$past(ovf)))
		else $error("status event lost");

	status_clear_a: assert property (
		accept && read && (address == OFF_STATUS) |=> status == '0)
		else $error("status not cleared by read");

	irq_level_a: assert property (
		irq == |(status & mask))
		else $error("interrupt level wrong");

	idle_wait_a: assert property (
		!read && !write |=> waitrequest)
		else $error("answer without request");

	operand_write_a: assert property (
		accept && write && (address == OFF_FIRST)
		|=> first_source_register == $past(writedata))
		else $error("first source write lost");

	second_write_a: assert property (
		accept && write && (address == OFF_SECOND)
		|=> second_source_register == $past(writedata))
		else $error("second source write lost");

	dest_write_a: assert property (
		accept && write && (address == OFF_DEST)
		|=> dest == $past(writedata))
		else $error("destination write lost");

	dest_read_a: assert property (
		read && waitrequest && (address == OFF_DEST)
		|=> readdata == $past(dest))
		else $error("destination read wrong");

	exc_write_a: assert property (
		accept && write && (address == OFF_EXC)
		|=> fixed_point_exception_register == $past(writedata[1:0]))
		else $error("exception register write lost");

	// The condition field is only ever written by a record form
	cond_ro_a: assert property (
		accept && write && (address == OFF_COND)
		|=> $stable(condition_field_zero))
		else $error("condition field took a bus write");

	unmapped_read_a: assert property (
		read && waitrequest && (address > OFF_MASK)
		|=> readdata == REG_RESET)
		else $error("unmapped read not zero");

	mask_write_a: assert property (
		accept && write && (address == OFF_MASK)
		|=> mask == $past(writedata[IRQ_W-1:0]))
		else $error("mask write lost");

endmodule
`default_nettype wire

// file: test/nmac_host.sv
`timescale 1ns/10ps
`default_nettype none
module nmac_host
	import nmac_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              waitrequest,
	input  wire logic [DATA_W-1:0] readdata,
	output logic      [ADDR_W-1:0] address,
	output logic                   read,
	output logic                   write,
	output logic      [DATA_W-1:0] writedata
);
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
	end
	// An edge passes before each request, so no strobe is set twice at once
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
	import nmac_pkg::*;
;
	logic              clock;
	logic              srst;
	logic              read;
	logic              write;
	logic              waitrequest;
	logic              irq;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata;
	logic [DATA_W-1:0] readdata;
	logic [DATA_W-1:0] q;
	logic [1:0]        m;
	exc_t              ex;
	cond_t             ec;
	int                err_total;
	int                checked;

	neg_mac_cross_halfword uut (.clock(clock), .srst(srst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq));
	nmac_host h (.clock(clock), .waitrequest(waitrequest),
		.readdata(readdata), .address(address), .read(read),
		.write(write), .writedata(writedata));

	task automatic chk(input string n, input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		h.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		h.xfer(1'b0, a, '0, q);
	endtask
	// Expected values come from a model kept here, not from the design
	task automatic op(input logic [31:0] d, a, b, input mac_form_t f);
		logic signed [31:0] p;
		logic signed [32:0] t;
		logic [31:0]        r;
		logic               v;
		p = $signed(a[15:0]) * $signed(b[31:16]);
		t = $signed({d[31], d}) - p;
		v = t[32] ^ t[31];
		r = (f.saturate && v) ? (t[32] ? SAT_MIN : SAT_MAX) : t[31:0];
		if (f.ovf_en) begin
			ex.overflow_flag = v;
			ex.so = ex.so | v;
		end
		if (f.record)
			ec = {r[31], !r[31] && r != 0, r == 0, ex.so};
		wr(OFF_FIRST, a);
		wr(OFF_SECOND, b);
		wr(OFF_DEST, d);
		wr(OFF_CMD, {29'h0, f});
		repeat (2) @(posedge clock);
		chk("irq", {31'h0, |(m & {v, 1'b1})}, {31'h0, irq});
		rd(OFF_DEST);
		chk("dest", r, q);
		rd(OFF_EXC);
		chk("exc", {30'h0, ex}, q);
		rd(OFF_COND);
		chk("cond", {28'h0, ec}, q);
		rd(OFF_STATUS);
		chk("status", {30'h0, v, 1'b1}, q);
		rd(OFF_STATUS);
		chk("status clr", 32'h0, q);
		repeat (2) @(posedge clock);
		chk("irq low", 32'h0, {31'h0, irq});
	endtask

	task automatic conclude();
		$display("err_total %0d checked %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#500000;
		err_total++;
		conclude();
	end
	task automatic pulse_reset();
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		ex = '0;
		ec = '0;
	endtask
	// The exception, mask, destination, condition and status registers and the interrupt line start from zero
	task automatic reset_values();
		rd(OFF_EXC);
		chk("exc rst", 32'h0, q);
		rd(OFF_MASK);
		chk("mask rst", 32'h0, q);
		rd(OFF_DEST);
		chk("dest rst", 32'h0, q);
		rd(OFF_COND);
		chk("cond rst", 32'h0, q);
		rd(OFF_STATUS);
		chk("status rst", 32'h0, q);
		chk("irq rst", 32'h0, {31'h0, irq});
	endtask
	task automatic all_forms();
		for (int k = 0; k < 4; k++) begin
			m = k[1:0];
			wr(OFF_MASK, {30'h0, m});
			rd(OFF_MASK);
			chk("mask", {30'h0, m}, q);
			for (int i = 0; i < 8; i++) begin
				// Clearing so first lets each form show stickiness anew
				wr(OFF_EXC, '0);
				ex = '0;
				op(32'h8000_0000, 32'h1234_0001, 32'h0001_5678, i[2:0]);
				op(32'h7fff_ffff, 32'hab12_ffff, 32'h0001_9abc, i[2:0]);
				op(32'h0000_0005, 32'hffff_0002, 32'h0003_ffff, i[2:0]);
				// Both halves negative, result zero: swapped halves give 6
				op(32'h0000_0006, 32'h0000_fffe, 32'hfffd_0000, i[2:0]);
			end
		end
	endtask
	task automatic map_edges();
		rd(4'h8);
		chk("unmapped", 32'h0, q);
		wr(OFF_COND, 32'hffff_ffff);
		rd(OFF_COND);
		chk("cond ro", {28'h0, ec}, q);
		wr(OFF_STATUS, 32'hffff_ffff);
		rd(OFF_STATUS);
		chk("status ro", 32'h0, q);
	endtask
	// A reset in mid-run must drop a pending interrupt and the registers that reset_values reads back
	task automatic mid_reset();
		wr(OFF_MASK, 32'h0000_0003);
		wr(OFF_CMD, 32'h0000_0000);
		repeat (2) @(posedge clock);
		chk("irq set", 32'h1, {31'h0, irq});
		pulse_reset();
		reset_values();
	endtask

	initial begin
		err_total = 0;
		checked = 0;
		pulse_reset();
		reset_values();
		all_forms();
		map_edges();
		mid_reset();
		conclude();
	end
endmodule
`default_nettype wire
